// file: logic/uart_rx_pkg.sv
// package: constants and field encodings for the serial receiver and baud generator
// What this block does
// - stop bit sampled low sets framing error
// - framing error stored with its word, reset clears
// - parity error only when odd/even parity chosen
// - parity error stored with its byte, reset clears
// - idle low from start detect to last stop sample
// - bit count follows data/parity and stop select
// - long break: zero word, framing error, idle
// - after break wait for high before start hunt
// - break stored as zero word; no reception until high
// - address detect: ninth bit one marks address
// - address detect ignores interrupt select, fires per address
// - loopback feeds transmit to receiver, pin cut off
// - bit rate is clock over sixteen times divisor plus one
package uart_rx_pkg;
  // ------------------------------------------------------------
  // field encodings
  // ------------------------------------------------------------
  localparam logic [1:0] DPS_8N = 2'h0;  // 8 data, no parity
  localparam logic [1:0] DPS_8E = 2'h1;  // 8 data, even parity
  localparam logic [1:0] DPS_8O = 2'h2;  // 8 data, odd parity
  localparam logic [1:0] DPS_9N = 2'h3;  // 9 data, no parity
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int OVERSAMPLE = 16;        // ticks per bit
  localparam logic [3:0] MID_TICK = 4'h7; // sample point inside a bit
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  // receiver states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_BITS  = 4'b0100,
    ST_WAITH = 4'b1000
  } rx_state_e;
endpackage : uart_rx_pkg

// file: logic/uart_rx_status.sv
// module: receiver with status flags, break handling, loopback and baud divider
`timescale 1ns/1ps
module uart_rx_status
  import uart_rx_pkg::*;
#(
  parameter int DIV_W = 16               // divisor width
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [DIV_W-1:0] baud_divisor_register,
  input  wire logic [1:0]       data_parity_select,
  input  wire logic             stop_bits_select,
  input  wire logic             address_detect_enable,
  input  wire logic [1:0]       receive_interrupt_select,
  input  wire logic             loopback_enable,
  input  wire logic             serial_receive_pin,
  input  wire logic             tx_line,          // transmitter's serial output
  output logic                  serial_transmit_pin,
  output logic                  baud_tick,        // 16x tick, shared with transmitter
  output logic                  receiver_idle_flag,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [8:0]            out_data,
  output logic                  framing_error_flag,
  output logic                  parity_error_flag,
  output logic                  receive_data_available,
  output logic                  rx_interrupt
);
  // widths outside 1..16 cannot hold the sixteen-bit divisor field
  if (DIV_W < 1 || DIV_W > 16) begin : g_div_w_check
    $error("divisor width must be 1..16");
  end

  // ------------------------------------------------------------
  // baud divider
  // ------------------------------------------------------------
  logic [DIV_W-1:0] div_reg;             // down counter
  wire              div_zero = (div_reg == '0);
  always_ff @(posedge mclk) begin
    if (!rst_n) div_reg <= '0;
    else if (div_zero) div_reg <= baud_divisor_register;
    else div_reg <= div_reg - 1'b1;
  end
  assign baud_tick = div_zero;

  // ------------------------------------------------------------
  // line select and synchroniser
  // ------------------------------------------------------------
  assign serial_transmit_pin = tx_line;  // pin keeps working in loopback
  logic pin_s1_reg, pin_s2_reg;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= serial_receive_pin;
      pin_s2_reg <= pin_s1_reg;
    end
  end
  wire line = loopback_enable ? tx_line : pin_s2_reg;

  // ------------------------------------------------------------
  // frame length and parity decode
  // ------------------------------------------------------------
  wire       nine_bit   = (data_parity_select == DPS_9N);
  wire       has_parity = (data_parity_select == DPS_8E) || (data_parity_select == DPS_8O);
  // data+parity bits, then stop bits follow
  wire [3:0] body_bits  = (nine_bit || has_parity) ? 4'h9 : 4'h8;
  wire [3:0] last_bit   = body_bits + (stop_bits_select ? 4'h2 : 4'h1);

  // ------------------------------------------------------------
  // receiver state machine
  // ------------------------------------------------------------
  rx_state_e  st_reg;
  logic [3:0] tick_reg;                  // oversample phase
  logic [3:0] bit_reg;                   // bits taken after start
  logic [8:0] shift_reg;                 // data+parity, lsb first
  logic       framing_error_flag_reg;
  logic       push;                      // one-cycle word done
  wire        mid = baud_tick && (tick_reg == MID_TICK);
  wire [7:0]  d8  = shift_reg[7:0];
  wire        par_bad = has_parity &&
                (^{d8, shift_reg[8]} != (data_parity_select == DPS_8O));
  wire        stop_pos = (bit_reg > body_bits);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg    <= ST_IDLE;
      tick_reg  <= 4'h0;
      bit_reg   <= 4'h0;
      shift_reg <= 9'h000;
      framing_error_flag_reg  <= 1'b0;
      push      <= 1'b0;
    end else begin
      push <= 1'b0;
      if (baud_tick) tick_reg <= tick_reg + 4'h1;
      case (st_reg)
        ST_IDLE: begin
          if (!line) begin               // start edge found
            st_reg   <= ST_START;
            tick_reg <= 4'h0;
            framing_error_flag_reg <= 1'b0;
          end
        end
        ST_START: begin
          if (mid) begin
            if (line) st_reg <= ST_IDLE; // glitch, not a start
            else begin
              st_reg  <= ST_BITS;
              bit_reg <= 4'h1;
            end
          end
        end
        ST_BITS: begin
          if (mid) begin
            bit_reg <= bit_reg + 4'h1;
            if (!stop_pos) shift_reg[bit_reg-4'h1] <= line;
            else if (!line) framing_error_flag_reg <= 1'b1;
            if (bit_reg == last_bit) begin
              push <= 1'b1;
              // low stop level: line may be in break, wait for high
              st_reg <= (!line || framing_error_flag_reg) ? ST_WAITH : ST_IDLE;
            end
          end
        end
        ST_WAITH: begin
          if (line) st_reg <= ST_IDLE;
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end
  // idle flag also reads one while waiting out a break
  assign receiver_idle_flag = (st_reg == ST_IDLE) || (st_reg == ST_WAITH);
  wire framing_error_flag_now = framing_error_flag_reg || (stop_pos && !line);

  // ------------------------------------------------------------
  // capture of the finished word: flags travel with data
  // ------------------------------------------------------------
  logic [10:0] word_reg;                 // {parity_error_flag, framing_error_flag, data}
  always_ff @(posedge mclk) begin
    if (!rst_n) word_reg <= 11'h000;
    else if (mid && st_reg == ST_BITS && bit_reg == last_bit)
      word_reg <= {par_bad, framing_error_flag_now,
                   (nine_bit ? shift_reg[8] : 1'b0), d8};
  end

  // ------------------------------------------------------------
  // two-entry buffer; full buffer drops the newest word
  // ------------------------------------------------------------
  logic [10:0] buf_reg [2];
  logic        rd_reg, wr_reg;
  logic [1:0]  cnt_reg;
  wire         in_ok = push && (cnt_reg != 2'h2);
  wire         out_ok = out_valid && out_ready;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_reg  <= 1'b0;
      wr_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (in_ok) begin
        buf_reg[wr_reg] <= word_reg;
        wr_reg          <= ~wr_reg;
      end
      if (out_ok) rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, in_ok} - {1'b0, out_ok};
    end
  end
  assign out_valid              = (cnt_reg != 2'h0);
  assign receive_data_available = out_valid;
  wire [10:0] head = out_valid ? buf_reg[rd_reg] : 11'h000;
  assign out_data           = head[8:0];
  assign framing_error_flag = head[9];
  assign parity_error_flag  = head[10];

  // ------------------------------------------------------------
  // receive interrupt pulse
  // ------------------------------------------------------------
  wire is_addr = address_detect_enable && nine_bit && word_reg[8];
  wire sel_int = (receive_interrupt_select[1]) ? (cnt_reg != 2'h0) : 1'b1;
  always_ff @(posedge mclk) begin
    if (!rst_n) rx_interrupt <= 1'b0;
    else if (address_detect_enable && nine_bit) rx_interrupt <= in_ok && is_addr;
    else rx_interrupt <= in_ok && sel_int;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_tick_reload: assert property (@(posedge mclk) disable iff (!rst_n)
    baud_tick |=> div_reg == $past(baud_divisor_register))
    else $error("divider did not reload");
  a_loop_select: assert property (@(posedge mclk) disable iff (!rst_n)
    loopback_enable |-> serial_transmit_pin == tx_line)
    else $error("transmit pin not driven in loopback");
  a_idle_start: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg == ST_IDLE && !line) |=> !receiver_idle_flag)
    else $error("idle flag high after start");
  a_break_wait: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg == ST_WAITH && !line) |=> st_reg == ST_WAITH)
    else $error("low line taken as start after break");
  a_push_space: assert property (@(posedge mclk) disable iff (!rst_n)
    push |=> !push)
    else $error("double word push");
  a_parity_none: assert property (@(posedge mclk) disable iff (!rst_n)
    (push && !has_parity) |=> !word_reg[10])
    else $error("parity error without parity");
  a_addr_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    (in_ok && address_detect_enable && nine_bit && !word_reg[8]) |=> !rx_interrupt)
    else $error("interrupt for data word in address mode");
  a_count_max: assert property (@(posedge mclk) disable iff (!rst_n)
    cnt_reg <= 2'h2)
    else $error("buffer count overflow");
  // last stop position sampled: the frame is complete
  sequence s_frame_end;
    mid && st_reg == ST_BITS && bit_reg == last_bit;
  endsequence
  // a stored word needs room at push time; a full buffer drops it on purpose
  a_word_stored: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_frame_end ##1 (cnt_reg != 2'h2)) |=> receive_data_available)
    else $error("finished word not made available");
  a_stop_framing_error_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    (mid && st_reg == ST_BITS && bit_reg == last_bit && (framing_error_flag_reg || !line)) |=> word_reg[9])
    else $error("low stop level not flagged with its word");
  a_idle_after_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    s_frame_end |=> receiver_idle_flag)
    else $error("idle flag low after stop bit");
  // in loopback a low receive pin must not start a frame
  a_loop_cutoff: assert property (@(posedge mclk) disable iff (!rst_n)
    (loopback_enable && st_reg == ST_IDLE && tx_line) |=> st_reg == ST_IDLE)
    else $error("receive pin reached receiver in loopback");
endmodule : uart_rx_status

// file: test/serial_station.sv
// remote station: drives one asynchronous serial line, lsb first
`timescale 1ns/1ps
module serial_station #(
  parameter int BIT = 16  // clocks per bit time
) (
  input  wire logic mclk,
  output logic      line
);
  initial line = 1'b1;  // idle high, as a pulled-up line
  // --------------------------------------------------------------
  // framing tasks, all changes at the falling edge
  // --------------------------------------------------------------
  // start, data bits, two stop slots; a second slot of one is idle
  task automatic send(input logic [8:0] d, input int nb, input logic [1:0] sp);
    line = 1'b0;
    repeat (BIT) @(negedge mclk);
    for (int i = 0; i < nb + 2; i++) begin
      line = (i < nb) ? d[i] : sp[i-nb];
      repeat (BIT) @(negedge mclk);
    end
    line = 1'b1;
  endtask : send
  // line held low for n bit times, then released high
  task automatic low(input int n);
    line = 1'b0;
    repeat (n * BIT) @(negedge mclk);
    line = 1'b1;
  endtask : low
endmodule : serial_station

// file: test/uart_rx_status_tb_top.sv
// testbench: serial receiver frames, errors, break, loopback, buffer, baud
`timescale 1ns/1ps
module uart_rx_status_tb_top
  import uart_rx_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n, stop2, aden, lpb, pin, txl, ready;
  logic [15:0] div;
  logic [1:0]  dps, isel;
  logic        stp, tick, idle, valid, fe, pe, rxda, rx_irq;
  logic [8:0]  dout;
  int          n_errors = 0;
  int          checked = 0;
  int          n_irq = 0;    // interrupt pulses seen so far
  always #50 mclk = ~mclk;  // 10 MHz
  // pulses last one clock, so each is caught once at the falling edge
  always @(negedge mclk) if (rx_irq === 1'b1) n_irq <= n_irq + 1;
  uart_rx_status uart_rx_status_inst (.mclk(mclk), .rst_n(rst_n),
    .baud_divisor_register(div), .data_parity_select(dps), .stop_bits_select(stop2),
    .address_detect_enable(aden), .receive_interrupt_select(isel),
    .loopback_enable(lpb), .serial_receive_pin(pin), .tx_line(txl),
    .serial_transmit_pin(stp), .baud_tick(tick), .receiver_idle_flag(idle),
    .out_valid(valid), .out_ready(ready), .out_data(dout), .framing_error_flag(fe),
    .parity_error_flag(pe), .receive_data_available(rxda), .rx_interrupt(rx_irq));
  serial_station #(.BIT(16)) pin_station (.mclk(mclk), .line(pin));
  serial_station #(.BIT(16)) loop_station (.mclk(mclk), .line(txl));
  // --------------------------------------------------------------
  // compare, wait and read tasks
  // --------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic check(input string nm, input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // bounded wait for a buffered word; a hang ends the run
  task automatic wait_valid();
    int i;
    for (i = 0; i < 4000 && valid !== 1'b1; i++) @(negedge mclk);
    if (i == 4000) begin
      n_errors++;
      finish_test();
    end
  endtask : wait_valid
  // take the head word, compare it, release it with one ready pulse
  task automatic get(input logic [8:0] d, input logic efe, input logic epe);
    wait_valid();
    check("data", dout, d);
    check("framing_error_flag", fe, efe);
    check("parity_error_flag", pe, epe);
    check("avail", rxda, 1'b1);
    ready = 1'b1;
    @(negedge mclk);
    ready = 1'b0;
    @(negedge mclk);  // an edge apart, so a following get raises ready anew
  endtask : get
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    int n;
    rst_n = 1'b0;
    div   = 16'h0000;
    dps   = DPS_8N;
    stop2 = 1'b0;
    aden  = 1'b0;
    isel  = 2'h3;
    lpb   = 1'b0;
    ready = 1'b0;
    repeat (16) @(negedge mclk);
    rst_n = 1;
    check("idle", idle, 1'b1);
    // every data/parity mode; bit 8 is one in each mode that sends nine bits, 8 data no parity sends eight
    for (int m = 0; m < 4; m++) begin
      dps = 2'(m);
      aden = (m == 3);
      n = n_irq;
      fork
        pin_station.send(9'h103, (m == 0) ? 8 : 9, 2'b11);
        begin repeat (40) @(negedge mclk); check("idle", idle, 1'b0); end
      join
      get((m == 3) ? 9'h103 : 9'h003, 1'b0, m == 1);
      if (m == 3) check("irq", 9'(n_irq - n), 9'h001);
      check("idle", idle, 1'b1);
    end
    // address mode still on: ninth bit zero is data and raises nothing
    n = n_irq;
    pin_station.send(9'h055, 9, 2'b11);
    get(9'h055, 1'b0, 1'b0);
    check("irq", 9'(n_irq - n), 9'h000);
    aden  = 1'b0;
    dps   = DPS_8N;
    stop2 = 1'b1;
    // second stop slot low, then a reset clears the stored flag
    pin_station.send(9'h0ff, 8, 2'b01);
    wait_valid();
    check("framing_error_flag", fe, 1'b1);
    rst_n = 0;
    @(negedge mclk);
    rst_n = 1;
    stop2 = 0;
    check("framing_error_flag", fe, 1'b0);
    check("parity_error_flag", pe, 1'b0);
    // long break, then a normal word once the line is high again
    pin_station.low(15);
    check("idle", idle, 1'b1);
    get(9'h000, 1'b1, 1'b0);
    pin_station.send(9'h05a, 8, 2'b11);
    get(9'h05a, 1'b0, 1'b0);
    // receiver stalled: two words kept, the third dropped; each kept word interrupts
    isel = 2'h0;
    n = n_irq;
    for (int k = 1; k < 4; k++) pin_station.send(9'(k * 17), 8, 2'b11);
    check("irq", 9'(n_irq - n), 9'h002);
    get(9'h011, 1'b0, 1'b0);
    get(9'h022, 1'b0, 1'b0);
    check("valid", valid, 1'b0);
    // loopback: mode set, then loopback, then transmission; pin held low
    lpb = 1'b1;
    @(negedge mclk);
    fork
      pin_station.low(12);
      loop_station.send(9'h03c, 8, 2'b11);
      begin repeat (24) @(negedge mclk); check("txpin", stp, txl); end
    join
    // let the released pin pass the synchroniser before it is selected again
    repeat (4) @(negedge mclk);
    lpb = 1'b0;
    get(9'h03c, 1'b0, 1'b0);
    // baud ticks every divisor plus one clocks
    div = 16'h0002;
    for (n = 0; n < 20 && tick !== 1'b1; n++) @(negedge mclk);
    @(negedge mclk);
    for (n = 1; n < 20 && tick !== 1'b1; n++) @(negedge mclk);
    check("tick", 9'(n), 9'(div + 1));
    finish_test();
  end
endmodule : uart_rx_status_tb_top
